// [logic/olsc_top.v]
// Channel control, protection and diagnosis of an eight-channel low-side switch.
`timescale 1ns/10ps
// Function
// - Output follows serial bit or combination
// - Per-channel AND or OR combining
// - Serial bits high active, parallel per pin
// - Map register routes remappable input anywhere
// - Reset map routes remappable input to channel 4
// - Per-channel fast or slow switching select
// - Overtemperature switches off at once, flagged
// - Auto-restart or latching per channel
// - Auto-restart resumes after cooling if requested
// - Latch cleared by new request rising edge
// - Overtemperature evaluated only while channel on
// - Shutdown mode cuts off after overload delay
// - Diagnosis bits shifted out on serial output
// - Polarity pin high: active high inputs
// - Limit-only mode flags fault, stays on
// - Reset turns outputs off, clears diagnosis
// - Fault output low on any channel error
`include "olsc_consts.vh"

module olsc_top #(
    parameter NCH = 8
) (
    input wire core_clk,
    input wire rst,
    input wire [7:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [15:0] reg_rdata,
    input wire first_parallel_input,
    input wire second_parallel_input,
    input wire third_parallel_input,
    input wire remappable_parallel_input,
    input wire input_polarity_select_pin,
    input wire [7:0] ot_sense,
    input wire [7:0] ilim_active,
    input wire spi_cs_n,
    input wire spi_sclk,
    output reg spi_so_o,
    output reg spi_so_oe,
    output reg [7:0] ch_on,
    output reg [7:0] ch_slow,
    output reg fault_n_o,
    output reg fault_n_oe
);

    // ****************************************************************
    // Cycle counts derived from the timing figures.
    // ****************************************************************
    // Least overload delay, rounded up to whole cycles.
    localparam integer OVL_INT = `OLSC_OVL_US * `OLSC_CLK_MHZ;
    localparam [10:0] OVL_CYC = OVL_INT[10:0];
    // Longest fault filtering time, rounded down to whole cycles.
    localparam integer FILT_INT = `OLSC_FILT_US * `OLSC_CLK_MHZ;
    localparam [10:0] FILT_CYC = FILT_INT[10:0];
    // Width of the synchronised input vector.
    localparam NSYNC = 23;
    // Idle levels of the pins: select deselected high, polarity pin pulled up.
    localparam [NSYNC-1:0] SYNC_IDLE = 23'h500000;

    // ****************************************************************
    // Input synchronisers.
    // ****************************************************************
    // Raw asynchronous inputs gathered into one vector.
    wire [NSYNC-1:0] async_in;
    // Three sampling stages and the agreed value.
    reg [NSYNC-1:0] s1_r;
    reg [NSYNC-1:0] s2_r;
    reg [NSYNC-1:0] s3_r;
    reg [NSYNC-1:0] f_r;

    assign async_in = {spi_cs_n, spi_sclk, input_polarity_select_pin,
                       remappable_parallel_input, third_parallel_input,
                       second_parallel_input, first_parallel_input,
                       ot_sense, ilim_active};

    genvar b;
    generate
        for (b = 0; b < NSYNC; b = b + 1) begin : g_sync
            // Each bit passes three flops; a change counts once stages two and three agree.
            always @(posedge core_clk) begin
                if (rst) begin
                    // Reset to the idle level, so no false select edge follows reset.
                    s1_r[b] <= SYNC_IDLE[b];
                    s2_r[b] <= SYNC_IDLE[b];
                    s3_r[b] <= SYNC_IDLE[b];
                    f_r[b] <= SYNC_IDLE[b];
                end else begin
                    s1_r[b] <= async_in[b];
                    s2_r[b] <= s1_r[b];
                    s3_r[b] <= s2_r[b];
                    if (s2_r[b] == s3_r[b]) begin
                        f_r[b] <= s3_r[b];
                    end
                end
            end
        end
    endgenerate

    // Named views of the filtered inputs.
    wire [7:0] ilim_f = f_r[7:0];
    wire [7:0] ot_f = f_r[15:8];
    wire [3:0] par_f = f_r[19:16];
    wire pol_f = f_r[20];
    wire sclk_f = f_r[21];
    wire cs_n_f = f_r[22];

    // ****************************************************************
    // Configuration registers.
    // ****************************************************************
    // Serial on/off bits, high active.
    reg [7:0] ser_r;
    // Per-channel enable of the parallel combination.
    reg [7:0] pen_r;
    // Per-channel combining function, 1 selects AND, 0 selects OR.
    reg [7:0] and_r;
    // Channels driven by the remappable parallel input.
    reg [7:0] map_r;
    // Per-channel slow switching select.
    reg [7:0] slow_r;
    // Per-channel overtemperature latching select.
    reg [7:0] otl_r;
    // Per-channel overload shutdown select.
    reg [7:0] ols_r;
    // Diagnosis flags of all channels, driven by the channel blocks.
    wire [7:0] ot_flag;
    wire [7:0] ol_flag;
    // Diagnosis word, two bits per channel, channel 8 in the top bits.
    wire [15:0] diag_w;
    // Diagnosis read strobe, which clears the flags.
    wire diag_clr = reg_rd && (reg_addr == `OLSC_A_DIAG);
    // A write strobe to any address; the case below decodes the address.
    wire wr_any = reg_wr;

    // Software writes steer the channel logic; reset restores defaults.
    always @(posedge core_clk) begin
        if (rst) begin
            ser_r <= `OLSC_R_SER;
            pen_r <= `OLSC_R_PEN;
            and_r <= `OLSC_R_AND;
            map_r <= `OLSC_R_MAP;
            slow_r <= `OLSC_R_SLOW;
            otl_r <= `OLSC_R_OTL;
            ols_r <= `OLSC_R_OLS;
        end else if (wr_any) begin
            case (reg_addr)
                `OLSC_A_SER: begin
                    ser_r <= reg_wdata[7:0];
                end
                `OLSC_A_PEN: begin
                    pen_r <= reg_wdata[7:0];
                end
                `OLSC_A_AND: begin
                    and_r <= reg_wdata[7:0];
                end
                `OLSC_A_MAP: begin
                    map_r <= reg_wdata[7:0];
                end
                `OLSC_A_SLOW: begin
                    slow_r <= reg_wdata[7:0];
                end
                `OLSC_A_OTL: begin
                    otl_r <= reg_wdata[7:0];
                end
                `OLSC_A_OLS: begin
                    ols_r <= reg_wdata[7:0];
                end
                default: begin
                    // Read-only and unmapped addresses ignore writes.
                    ser_r <= ser_r;
                end
            endcase
        end
    end

    // Read data stand in the cycle after the strobe; unmapped reads give zero.
    always @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `OLSC_A_SER: begin
                    reg_rdata <= {8'h00, ser_r};
                end
                `OLSC_A_PEN: begin
                    reg_rdata <= {8'h00, pen_r};
                end
                `OLSC_A_AND: begin
                    reg_rdata <= {8'h00, and_r};
                end
                `OLSC_A_MAP: begin
                    reg_rdata <= {8'h00, map_r};
                end
                `OLSC_A_SLOW: begin
                    reg_rdata <= {8'h00, slow_r};
                end
                `OLSC_A_OTL: begin
                    reg_rdata <= {8'h00, otl_r};
                end
                `OLSC_A_OLS: begin
                    reg_rdata <= {8'h00, ols_r};
                end
                `OLSC_A_STAT: begin
                    reg_rdata <= {8'h00, ch_on};
                end
                `OLSC_A_DIAG: begin
                    reg_rdata <= diag_w;
                end
                default: begin
                    reg_rdata <= 16'h0000;
                end
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // ****************************************************************
    // Per-channel control and protection.
    // ****************************************************************
    // Next state of every channel driver.
    wire [7:0] on_nxt;

    genvar i;
    generate
        for (i = 0; i < NCH; i = i + 1) begin : g_ch
            // Dedicated parallel pin of this channel; channels above three have none.
            wire own_pin = (i < 3) ? par_f[i % 3] : 1'b0;
            // Pin level before polarity; mapped channels take the remappable input.
            wire pin_lvl = map_r[i] ? par_f[3] : own_pin;
            // Active level: high when the polarity pin is high, low otherwise.
            wire par_on = pol_f ? pin_lvl : ~pin_lvl;
            // Parallel source exists only for mapped channels or pins one to three.
            wire par_use = pen_r[i] & (map_r[i] | (i < 3));
            // Combined input request of the channel.
            wire req = !par_use ? ser_r[i] :
                       (and_r[i] ? (ser_r[i] & par_on) : (ser_r[i] | par_on));
            // Previous request for edge detection.
            reg req_q;
            // Overtemperature and overload hold latches.
            reg ot_hold;
            reg ol_hold;
            // Sticky diagnosis flags.
            reg ot_d;
            reg ol_d;
            // Duration of current limiting while on.
            reg [10:0] lim_cnt;
            // Rising edge of the combined request.
            wire rise = req & ~req_q;
            // Overtemperature event, only while the channel conducts.
            wire ot_ev = ot_f[i] & ch_on[i];
            // Limiting lasted the overload delay.
            wire ovl_hit = ilim_f[i] & ch_on[i] & (lim_cnt >= OVL_CYC - 11'h001);
            // Limiting lasted the fault filtering time.
            wire filt_hit = ilim_f[i] & ch_on[i] & (lim_cnt >= FILT_CYC - 11'h001);
            // Overload shutdown in shutdown mode.
            wire ol_ev = ols_r[i] & ovl_hit;

            assign on_nxt[i] = req & ~ot_ev & ~ot_hold & ~ol_ev & ~ol_hold;
            assign ot_flag[i] = ot_d;
            assign ol_flag[i] = ol_d;

            // Holds, counters and flags; every set wins over a clear in the same cycle.
            always @(posedge core_clk) begin
                if (rst) begin
                    req_q <= 1'b0;
                    ot_hold <= 1'b0;
                    ol_hold <= 1'b0;
                    ot_d <= 1'b0;
                    ol_d <= 1'b0;
                    lim_cnt <= 11'h000;
                end else begin
                    req_q <= req;
                    // Overtemperature hold: auto mode frees it on cooling, latch mode on an edge.
                    if (ot_ev) begin
                        ot_hold <= 1'b1;
                    end else if (otl_r[i] ? rise : ~ot_f[i]) begin
                        ot_hold <= 1'b0;
                    end
                    // Overload hold is freed only by a new request edge.
                    if (ol_ev) begin
                        ol_hold <= 1'b1;
                    end else if (rise) begin
                        ol_hold <= 1'b0;
                    end
                    // Count limiting time while the channel is on.
                    if (ilim_f[i] & ch_on[i]) begin
                        if (lim_cnt != FILT_CYC) begin
                            lim_cnt <= lim_cnt + 11'h001;
                        end
                    end else begin
                        lim_cnt <= 11'h000;
                    end
                    // Overtemperature diagnosis flag.
                    if (ot_ev) begin
                        ot_d <= 1'b1;
                    end else if (diag_clr) begin
                        ot_d <= 1'b0;
                    end
                    // Overload flag: filtered limiting, or a shutdown.
                    if (filt_hit | ol_ev) begin
                        ol_d <= 1'b1;
                    end else if (diag_clr) begin
                        ol_d <= 1'b0;
                    end
                end
            end

            assign diag_w[2*i+1:2*i] = {ot_d, ol_d};
        end
    endgenerate

    // ****************************************************************
    // Output drivers and fault pin.
    // ****************************************************************
    // Channel drivers, slew selects and the open-drain fault pin.
    always @(posedge core_clk) begin
        if (rst) begin
            ch_on <= 8'h00;
            ch_slow <= 8'h00;
            fault_n_o <= 1'b0;
            fault_n_oe <= 1'b0;
        end else begin
            ch_on <= on_nxt;
            ch_slow <= slow_r;
            fault_n_o <= 1'b0;
            fault_n_oe <= |(ot_flag | ol_flag);
        end
    end

    // ****************************************************************
    // Serial diagnosis output.
    // ****************************************************************
    // Previous select and clock levels for edge detection.
    reg cs_q;
    reg sclk_q;
    // Diagnosis shift register, most significant bit first.
    reg [15:0] sh_r;

    // Select fall loads the diagnosis; each clock rise shifts the next bit out.
    always @(posedge core_clk) begin
        if (rst) begin
            cs_q <= 1'b1;
            sclk_q <= 1'b0;
            sh_r <= 16'h0000;
            spi_so_o <= 1'b0;
            spi_so_oe <= 1'b0;
        end else begin
            cs_q <= cs_n_f;
            sclk_q <= sclk_f;
            if (cs_q & ~cs_n_f) begin
                sh_r <= diag_w;
            end else if (~cs_n_f & sclk_f & ~sclk_q) begin
                sh_r <= {sh_r[14:0], 1'b0};
            end
            spi_so_o <= sh_r[15];
            spi_so_oe <= ~cs_n_f;
        end
    end

endmodule

// [logic/olsc_consts.vh]
// Constants of the octal low-side channel control block.
`ifndef OLSC_CONSTS_VH
`define OLSC_CONSTS_VH

// ****************************************************************
// Register offsets (byte addresses on the plain register port).
// ****************************************************************
`define OLSC_A_SER 8'h00
`define OLSC_A_PEN 8'h04
`define OLSC_A_AND 8'h08
`define OLSC_A_MAP 8'h0C
`define OLSC_A_SLOW 8'h10
`define OLSC_A_OTL 8'h14
`define OLSC_A_OLS 8'h18
`define OLSC_A_STAT 8'h1C
`define OLSC_A_DIAG 8'h20

// ****************************************************************
// Reset values of the configuration registers.
// ****************************************************************
`define OLSC_R_SER 8'h00
`define OLSC_R_PEN 8'h0F
`define OLSC_R_AND 8'h00
`define OLSC_R_MAP 8'h08
`define OLSC_R_SLOW 8'h00
`define OLSC_R_OTL 8'h00
`define OLSC_R_OLS 8'h00

// ****************************************************************
// Field positions of the diagnosis word, two bits per channel.
// ****************************************************************
`define OLSC_D_OL 0
`define OLSC_D_OT 1

// ****************************************************************
// Timing figures in their own units.
// ****************************************************************
`define OLSC_CLK_MHZ 10
`define OLSC_OVL_US 10
`define OLSC_FILT_US 200
`define OLSC_FAST_US 15
`define OLSC_SLOW_US 60

`endif

// [test/olsc_assertions.sv]
// Concurrent checks on the ports of the channel control block.
`timescale 1ns/10ps
module olsc_checker (
    input wire core_clk,
    input wire rst,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_rdata,
    input wire [7:0] ot_sense,
    input wire spi_cs_n,
    input wire spi_so_oe,
    input wire [7:0] ch_on,
    input wire [7:0] ch_slow,
    input wire fault_n_o,
    input wire fault_n_oe
);
    genvar g;
    // ****************************************************************
    // Clocking for every check; the reset disable for all but a_reset_all_off.
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    // Reset leaves every driver, the fault pin and the serial output idle.
    a_reset_all_off: assert property (disable iff (1'b0) rst |=>
        ch_on == 8'h00 && ch_slow == 8'h00 && !fault_n_oe && !spi_so_oe)
        else $error("outputs still active after reset");
    // Read data stands only in the cycle after a read.
    a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data without a read");
    // The open-drain fault pin only ever pulls low.
    a_fault_pin_low: assert property (fault_n_o == 1'b0)
        else $error("fault pin driven high");
    // The serial output is released while select stays high.
    a_so_released: assert property (spi_cs_n [*6] |-> !spi_so_oe)
        else $error("serial output driven while deselected");
    // The serial output is driven while select stays low.
    a_so_driven: assert property (!spi_cs_n [*6] |-> spi_so_oe)
        else $error("serial output idle while selected");
    // A hot channel is never left on.
    generate
        for (g = 0; g < 8; g = g + 1) begin : ot_lane
            a_ot_cuts: assert property (ot_sense[g] [*7] |-> !ch_on[g])
                else $error("hot channel still on");
        end
    endgenerate
    // A trip of live channel 1 pulls the fault pin within four cycles.
    a_ot_flags: assert property ((ot_sense[0] && ch_on[0]) [*4] |-> ##[1:4] fault_n_oe)
        else $error("overtemperature without fault pin");
    // Slew selects only move after a register write or a reset.
    a_slow_cause: assert property (!$stable(ch_slow) |->
        $past(reg_wr) || $past(reg_wr, 2) || $past(rst))
        else $error("slew select changed without a write");
    // Main scenarios: a trip, a frame and a non-zero read.
    c_ot_trip: cover property ($fell(ch_on[0]) && fault_n_oe);
    c_frame: cover property ($rose(spi_so_oe));
    c_read: cover property (reg_rd ##1 reg_rdata != 16'h0000);
endmodule
bind olsc_top olsc_checker olsc_checker_inst (.core_clk, .rst, .reg_wr, .reg_rd,
    .reg_rdata, .ot_sense, .spi_cs_n, .spi_so_oe, .ch_on, .ch_slow, .fault_n_o, .fault_n_oe);

// [test/olsc_host_model.sv]
// Host model that clocks diagnosis frames out of the serial port.
`timescale 1ns/10ps
module olsc_host_model (
    input wire core_clk,
    output reg spi_cs_n,
    output reg spi_sclk,
    input wire spi_so_o,
    input wire spi_so_oe,
    output reg [15:0] rx_word
);
    integer k;
    // Select idles high and the serial clock rests low between frames.
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        rx_word = 16'h0000;
    end
    // One frame: long settle gap, lead, sixteen 800 ns clocks MSB first, lag.
    task frame;
        begin
            repeat (2000) @(posedge core_clk);
            spi_cs_n <= 1'b0;
            repeat (12) @(posedge core_clk);
            for (k = 15; k >= 0; k = k - 1) begin
                // A released line shows the inverse of its last bit, so a late enable never matches.
                rx_word[k] <= spi_so_oe ? spi_so_o : ~spi_so_o;
                spi_sclk <= 1'b1;
                repeat (4) @(posedge core_clk);
                spi_sclk <= 1'b0;
                repeat (4) @(posedge core_clk);
            end
            spi_cs_n <= 1'b1;
            repeat (4) @(posedge core_clk);
        end
    endtask
endmodule

// [test/tb_top.sv]
// Self-checking bench for the channel control block.
`timescale 1ns/10ps
`include "olsc_consts.vh"
module tb_top;
    reg core_clk, rst, reg_wr, reg_rd, in1, in2, in3, in4, pol;
    reg [7:0] reg_addr, ot_sense, ilim_active;
    reg [15:0] reg_wdata, got;
    wire [15:0] reg_rdata, rx_word;
    wire [7:0] ch_on, ch_slow;
    wire spi_cs_n, spi_sclk, spi_so_o, spi_so_oe, fault_n_o, fault_n_oe;
    integer err_total, checks_done, cyc, i;
    olsc_top olsc_top_inst (.core_clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .first_parallel_input(in1), .second_parallel_input(in2),
        .third_parallel_input(in3), .remappable_parallel_input(in4),
        .input_polarity_select_pin(pol), .ot_sense, .ilim_active, .spi_cs_n, .spi_sclk,
        .spi_so_o, .spi_so_oe, .ch_on, .ch_slow, .fault_n_o, .fault_n_oe);
    olsc_host_model olsc_host_model_inst (.core_clk, .spi_cs_n, .spi_sclk, .spi_so_o,
        .spi_so_oe, .rx_word);
    // ****************************************************************
    // Clock, hang guard and closing report.
    // ****************************************************************
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    task complete_run;
        begin
            if (err_total == 0 && checks_done > 0) begin
                $display("SIMULATION PASSED");
            end else begin
                $display("SIMULATION FAILED");
            end
            $finish;
        end
    endtask
    // A run far past its expected length counts as a failure.
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_total = err_total + 1;
            complete_run;
        end
    end
    // ****************************************************************
    // Bus tasks and comparison.
    // ****************************************************************
    task chk(input [15:0] g, input [15:0] e);
        begin
            checks_done = checks_done + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("unexpected at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task wt(input integer n);
        repeat (n) @(posedge core_clk);
    endtask
    // One-cycle write, then room for the output to follow.
    task wr(input [7:0] a, input [7:0] d);
        begin
            reg_addr <= a;
            reg_wdata <= {8'h00, d};
            reg_wr <= 1'b1;
            @(posedge core_clk);
            reg_wr <= 1'b0;
            wt(3);
        end
    endtask
    // One-cycle read; the data is taken in the cycle after.
    task rdc(input [7:0] a, input [15:0] e);
        begin
            reg_addr <= a;
            reg_rd <= 1'b1;
            @(posedge core_clk);
            reg_rd <= 1'b0;
            @(posedge core_clk);
            got = reg_rdata;
            chk(got, e);
        end
    endtask
    // ****************************************************************
    // Main sequence.
    // ****************************************************************
    initial begin
        {rst, pol} = 2'b11;
        {reg_wr, reg_rd, in1, in2, in3, in4} = 6'h00;
        {reg_addr, ot_sense, ilim_active, reg_wdata} = 40'h0;
        {err_total, checks_done, cyc} = 0;
        wt(4);
        rst <= 1'b0;
        wt(6);
        // Reset values, including status, diagnosis and an unmapped place.
        for (i = 0; i < 10; i = i + 1) begin
            rdc(8'(i * 4), {8'h00, (i == 1) ? `OLSC_R_PEN : (i == 3) ? `OLSC_R_MAP : 8'h00});
        end
        wr(`OLSC_A_PEN, 8'h00);
        wr(`OLSC_A_SER, 8'hA5);
        chk({8'h00, ch_on}, 16'h00A5);
        // Channel 1 combines by AND, channel 2 by OR, over all four cases.
        wr(`OLSC_A_PEN, 8'h0F);
        wr(`OLSC_A_AND, 8'h01);
        for (i = 0; i < 4; i = i + 1) begin
            in1 <= i[1];
            in2 <= i[1];
            wr(`OLSC_A_SER, {6'h00, i[0], i[0]});
            wt(6);
            chk({8'h00, ch_on}, {14'h0, i[1] | i[0], i[1] & i[0]});
        end
        // Low polarity: high pins are off, the remappable pin drives channel 4.
        pol <= 1'b0;
        {in1, in2, in3, in4} <= 4'hE;
        wr(`OLSC_A_SER, 8'h00);
        wt(8);
        chk({8'h00, ch_on}, 16'h0008);
        wr(`OLSC_A_PEN, 8'hFF);
        wr(`OLSC_A_MAP, 8'hF8);
        wt(2);
        chk({8'h00, ch_on}, 16'h00F8);
        {pol, in4} <= 2'b10;
        wr(`OLSC_A_PEN, 8'h00);
        wr(`OLSC_A_SLOW, 8'h5A);
        chk({8'h00, ch_slow}, 16'h005A);
        // Auto-restart trip on channel 1.
        wr(`OLSC_A_SER, 8'h01);
        ot_sense <= 8'h01;
        wt(8);
        chk({7'h0, fault_n_oe, ch_on}, 16'h0100);
        ot_sense <= 8'h00;
        wt(8);
        chk({7'h0, fault_n_oe, ch_on}, 16'h0101);
        rdc(`OLSC_A_DIAG, 16'h0002);
        wt(2);
        chk({fault_n_o, 6'h0, fault_n_oe, ch_on}, 16'h0001);
        // Latching trip needs a new rising request to come back.
        wr(`OLSC_A_OTL, 8'h01);
        ot_sense <= 8'h01;
        wt(8);
        ot_sense <= 8'h00;
        wt(8);
        chk({7'h0, fault_n_oe, ch_on}, 16'h0100);
        rdc(`OLSC_A_DIAG, 16'h0002);
        wr(`OLSC_A_SER, 8'h00);
        wr(`OLSC_A_SER, 8'h01);
        chk({7'h0, fault_n_oe, ch_on}, 16'h0001);
        // A hot channel that is off raises nothing.
        ot_sense <= 8'h02;
        wt(10);
        rdc(`OLSC_A_DIAG, 16'h0000);
        ot_sense <= 8'h00;
        // Overload with shutdown, cut off after 100 cycles of limiting.
        wr(`OLSC_A_OLS, 8'h01);
        ilim_active <= 8'h01;
        wt(90);
        chk({7'h0, fault_n_oe, ch_on}, 16'h0001);
        wt(25);
        chk({7'h0, fault_n_oe, ch_on}, 16'h0100);
        ilim_active <= 8'h00;
        rdc(`OLSC_A_DIAG, 16'h0001);
        wr(`OLSC_A_SER, 8'h00);
        wr(`OLSC_A_SER, 8'h01);
        chk({7'h0, fault_n_oe, ch_on}, 16'h0001);
        // Limit-only mode flags after the filter time and stays on.
        wr(`OLSC_A_OLS, 8'h00);
        ilim_active <= 8'h01;
        wt(1900);
        chk({7'h0, fault_n_oe, ch_on}, 16'h0001);
        wt(150);
        chk({7'h0, fault_n_oe, ch_on}, 16'h0101);
        ilim_active <= 8'h00;
        wt(6);
        rdc(`OLSC_A_DIAG, 16'h0001);
        // Diagnosis shifted out over the serial port.
        ot_sense <= 8'h01;
        wt(8);
        olsc_host_model_inst.frame();
        chk(rx_word, 16'h0002);
        ot_sense <= 8'h00;
        // Reset in mid-run clears outputs and diagnosis and restores the settings.
        rst <= 1'b1;
        wt(2);
        rst <= 1'b0;
        wt(1);
        chk({7'h0, fault_n_oe, ch_on}, 16'h0000);
        rdc(`OLSC_A_DIAG, 16'h0000);
        rdc(`OLSC_A_MAP, {8'h00, `OLSC_R_MAP});
        rdc(`OLSC_A_OTL, 16'h0000);
        complete_run;
    end
endmodule
